/* File: hw/asu_defines.vh */
`ifndef ASU_DEFINES_VH
`define ASU_DEFINES_VH
// parity mode field encodings
`define ASU_PAR_NONE 2'h0
`define ASU_PAR_ZERO 2'h1
`define ASU_PAR_ODD 2'h2
`define ASU_PAR_EVEN 2'h3
// default count clock divider, one less than base clock cycles per bit
`define ASU_DIV_DEFAULT 16'h006c
// fifo shape
`define ASU_FIFO_DEPTH 8
`define ASU_FIFO_AW 3
// receiver states
`define ASU_RS_IDLE 3'h0
`define ASU_RS_START 3'h1
`define ASU_RS_DATA 3'h2
`define ASU_RS_PAR 3'h3
`define ASU_RS_STOP 3'h4
// transmitter states
`define ASU_TS_IDLE 3'h0
`define ASU_TS_START 3'h1
`define ASU_TS_DATA 3'h2
`define ASU_TS_PAR 3'h3
`define ASU_TS_STOP 3'h4
`endif

/* File: hw/asu_fifo.v */
`timescale 1ns/1ps
`include "asu_defines.vh"
module asu_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = `ASU_FIFO_DEPTH,
    parameter AW = `ASU_FIFO_AW
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // fill side
    input wire in_valid,
    input wire [WIDTH-1:0] in_data,
    output wire in_ready,
    // drain side
    output wire out_valid,
    output wire [WIDTH-1:0] out_data,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;
    // full and empty come straight from the occupancy count
    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // storage has no reset, only pointers and count need one
    always @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
    // pointer and count bookkeeping
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

/* File: hw/asu_top.v */
`timescale 1ns/1ps
`include "asu_defines.vh"
module asu_top #(
    parameter DIV_WIDTH = 16
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // control bits
    input wire unit_power_bit,
    input wire tx_enable_bit,
    input wire rx_enable_bit,
    input wire parity_mode_hi,
    input wire parity_mode_lo,
    input wire char_length_select,
    input wire stop_length_select,
    input wire rx_error_irq_select,
    input wire [DIV_WIDTH-1:0] count_clock_div,
    // transmit write port
    input wire tx_wr_valid,
    input wire [7:0] transmit_buffer,
    output reg tx_wr_ready,
    // receive stream out
    output reg rx_valid,
    output reg [7:0] rx_data,
    input wire rx_ready,
    // error status read with one wait cycle
    input wire err_rd_req,
    output reg err_rd_ack,
    output reg [2:0] rx_error_status_reg,
    // status
    output reg tx_buffer_full_flag,
    output reg tx_shift_busy_flag,
    output reg tx_done_pulse,
    output reg rx_error_pulse,
    output reg rx_done_pulse,
    // serial lines
    input wire serial_rx_line,
    output reg serial_tx_line
);
    wire [1:0] par_mode = {parity_mode_hi, parity_mode_lo};
    wire [3:0] nbits = char_length_select ? 4'h8 : 4'h7;
    // shared tick counter per direction; the divider input is the count clock
    reg [DIV_WIDTH-1:0] rx_cnt;
    reg [DIV_WIDTH-1:0] tx_cnt;
    wire rx_tick = (rx_cnt == {DIV_WIDTH{1'b0}});
    wire tx_tick = (tx_cnt == {DIV_WIDTH{1'b0}});
    // parity of a character given mode; zero mode sends 0
    function par_bit;
        input [7:0] d;
        input [1:0] m;
        input c8;
        reg p;
        begin
            p = c8 ? ^d : ^d[6:0];
            case (m)
                `ASU_PAR_ODD: par_bit = ~p;
                `ASU_PAR_EVEN: par_bit = p;
                default: par_bit = 1'b0;
            endcase
        end
    endfunction

    // transmit fifo decouples the host write port from the shifter
    wire fifo_ready;
    wire fifo_valid;
    wire [7:0] fifo_data;
    reg tx_take;
    asu_fifo #(.WIDTH(8), .DEPTH(`ASU_FIFO_DEPTH), .AW(`ASU_FIFO_AW)) u_txq (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(tx_wr_valid && tx_enable_bit && unit_power_bit),
        .in_data(transmit_buffer),
        .in_ready(fifo_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(tx_take)
    );

    // transmitter
    reg [2:0] ts;
    reg [7:0] tsh;
    reg [3:0] tbit;
    reg tstop2;
    always @* begin
        tx_take = (ts == `ASU_TS_IDLE) && tx_enable_bit && unit_power_bit;
    end
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            ts <= `ASU_TS_IDLE;
            tsh <= 8'h00;
            tbit <= 4'h0;
            tstop2 <= 1'b0;
            tx_cnt <= {DIV_WIDTH{1'b0}};
            serial_tx_line <= 1'b1;
            tx_done_pulse <= 1'b0;
            tx_shift_busy_flag <= 1'b0;
            tx_buffer_full_flag <= 1'b0;
            tx_wr_ready <= 1'b0;
        end else begin
            tx_done_pulse <= 1'b0;
            tx_buffer_full_flag <= !fifo_ready;
            tx_wr_ready <= fifo_ready && tx_enable_bit && unit_power_bit;
            tx_shift_busy_flag <= (ts != `ASU_TS_IDLE);
            tx_cnt <= tx_tick ? count_clock_div : tx_cnt - 1'b1;
            if (!tx_enable_bit || !unit_power_bit) begin
                ts <= `ASU_TS_IDLE;
                serial_tx_line <= 1'b1;
            end else begin
                case (ts)
                    `ASU_TS_IDLE: begin
                        if (fifo_valid) begin
                            tsh <= fifo_data;
                            ts <= `ASU_TS_START;
                            tx_cnt <= count_clock_div;
                            serial_tx_line <= 1'b0;
                            tx_shift_busy_flag <= 1'b1;
                        end
                    end
                    `ASU_TS_START: if (tx_tick) begin
                        serial_tx_line <= tsh[0];
                        tbit <= 4'h1;
                        ts <= `ASU_TS_DATA;
                    end
                    `ASU_TS_DATA: if (tx_tick) begin
                        if (tbit == nbits) begin
                            if (par_mode != `ASU_PAR_NONE) begin
                                serial_tx_line <= par_bit(tsh, par_mode, char_length_select);
                                ts <= `ASU_TS_PAR;
                            end else begin
                                serial_tx_line <= 1'b1;
                                tstop2 <= stop_length_select;
                                ts <= `ASU_TS_STOP;
                            end
                        end else begin
                            serial_tx_line <= tsh[tbit[2:0]];
                            tbit <= tbit + 1'b1;
                        end
                    end
                    `ASU_TS_PAR: if (tx_tick) begin
                        serial_tx_line <= 1'b1;
                        tstop2 <= stop_length_select;
                        ts <= `ASU_TS_STOP;
                    end
                    `ASU_TS_STOP: if (tx_tick) begin
                        if (tstop2) begin
                            tstop2 <= 1'b0;
                        end else begin
                            ts <= `ASU_TS_IDLE;
                            tx_done_pulse <= 1'b1;
                        end
                    end
                    default: ts <= `ASU_TS_IDLE;
                endcase
            end
        end
    end

    // receiver; samples mid-bit, half period after start edge
    reg [2:0] rs;
    reg [7:0] rsh;
    reg [3:0] rbit;
    reg rpar;
    reg rx_prev;
    reg pe_flag;
    reg fe_flag;
    reg ovr_flag;
    reg rd_wait;
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            rs <= `ASU_RS_IDLE;
            rsh <= 8'h00;
            rbit <= 4'h0;
            rpar <= 1'b0;
            rx_prev <= 1'b1;
            rx_cnt <= {DIV_WIDTH{1'b0}};
            pe_flag <= 1'b0;
            fe_flag <= 1'b0;
            ovr_flag <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            rx_done_pulse <= 1'b0;
            rx_error_pulse <= 1'b0;
            rd_wait <= 1'b0;
            err_rd_ack <= 1'b0;
            rx_error_status_reg <= 3'h0;
        end else begin
            rx_prev <= serial_rx_line;
            rx_done_pulse <= 1'b0;
            rx_error_pulse <= 1'b0;
            err_rd_ack <= 1'b0;
            rx_cnt <= rx_tick ? count_clock_div : rx_cnt - 1'b1;
            if (rx_valid && rx_ready) begin
                rx_valid <= 1'b0;
            end
            // one wait cycle: request taken, data returned the edge after
            rd_wait <= err_rd_req && !rd_wait && !err_rd_ack;
            if (rd_wait) begin
                err_rd_ack <= 1'b1;
                rx_error_status_reg <= {pe_flag, fe_flag, ovr_flag};
                pe_flag <= 1'b0;
                fe_flag <= 1'b0;
                ovr_flag <= 1'b0;
            end
            if (!rx_enable_bit || !unit_power_bit) begin
                rs <= `ASU_RS_IDLE;
            end else begin
                case (rs)
                    `ASU_RS_IDLE: if (rx_prev && !serial_rx_line) begin
                        rx_cnt <= {1'b0, count_clock_div[DIV_WIDTH-1:1]};
                        rs <= `ASU_RS_START;
                    end
                    `ASU_RS_START: if (rx_tick) begin
                        rs <= serial_rx_line ? `ASU_RS_IDLE : `ASU_RS_DATA;
                        rbit <= 4'h0;
                        rsh <= 8'h00;
                    end
                    `ASU_RS_DATA: if (rx_tick) begin
                        rsh[rbit[2:0]] <= serial_rx_line;
                        rbit <= rbit + 1'b1;
                        if (rbit + 1'b1 == nbits) begin
                            rs <= (par_mode != `ASU_PAR_NONE) ? `ASU_RS_PAR : `ASU_RS_STOP;
                        end
                    end
                    `ASU_RS_PAR: if (rx_tick) begin
                        rpar <= serial_rx_line;
                        rs <= `ASU_RS_STOP;
                    end
                    // only this first stop bit is checked
                    `ASU_RS_STOP: if (rx_tick) begin
                        rs <= `ASU_RS_IDLE;
                        rx_done_pulse <= 1'b1;
                        // parity check rule per mode; set beats read clear
                        case (par_mode)
                            `ASU_PAR_ODD, `ASU_PAR_EVEN: if (rpar != par_bit(rsh, par_mode, char_length_select)) begin
                                pe_flag <= 1'b1;
                                rx_error_pulse <= 1'b1;
                            end
                            `ASU_PAR_ZERO: ;
                            default: ;
                        endcase
                        if (!serial_rx_line) begin
                            fe_flag <= 1'b1;
                            rx_error_pulse <= 1'b1;
                        end
                        // overrun: keep old buffer, drop new one
                        if (rx_valid && !rx_ready) begin
                            ovr_flag <= 1'b1;
                            rx_error_pulse <= 1'b1;
                        end else begin
                            rx_data <= rsh;
                            rx_valid <= 1'b1;
                        end
                    end
                    default: rs <= `ASU_RS_IDLE;
                endcase
            end
        end
    end
endmodule

/* File: verif/asu_remote_node.sv */
`timescale 1ns/1ps
module asu_remote_node #(
    parameter BIT = 4
) (
    // clock
    input wire ref_clk,
    // serial lines, seen from the remote node
    output reg rx_line,
    input wire tx_line
);
    // idle high so enabling the receiver never starts a frame
    initial rx_line = 1'b1;

    // start bit, then the given bits lsb first, then idle
    task send(input [15:0] f);
        integer i;
        begin
            @(posedge ref_clk) rx_line <= 1'b0;
            repeat (BIT - 1) @(posedge ref_clk);
            for (i = 0; i < f[15:12]; i++) begin
                @(posedge ref_clk) rx_line <= f[i];
                repeat (BIT - 1) @(posedge ref_clk);
            end
            @(posedge ref_clk) rx_line <= 1'b1;
        end
    endtask

    // mid-bit sampling, so a wrong bit length drifts into wrong bits
    task recv(input [3:0] n, output [11:0] v);
        integer i;
        begin
            v = 12'h000;
            @(negedge tx_line);
            repeat (BIT / 2) @(posedge ref_clk);
            for (i = 0; i < n; i++) begin
                repeat (BIT) @(posedge ref_clk);
                v[i] = tx_line;
            end
        end
    endtask
endmodule

/* File: verif/asu_top_assertions.sv */
`timescale 1ns/1ps
module asu_top_chk (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // watched ports
    input wire rx_enable_bit,
    input wire rx_ready,
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire err_rd_req,
    input wire err_rd_ack,
    input wire [2:0] rx_error_status_reg,
    input wire tx_shift_busy_flag,
    input wire tx_buffer_full_flag,
    input wire tx_done_pulse,
    input wire rx_error_pulse,
    input wire serial_tx_line
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // status read answers two edges after the request, one wait cycle
    chk_ack_wait: assert property (err_rd_ack |-> $past(err_rd_req, 2))
        else $error("ack without request");
    chk_req_ack: assert property ($rose(err_rd_req) |-> ##1 !err_rd_ack ##1 err_rd_ack)
        else $error("ack not after one wait cycle");
    chk_ack_pulse: assert property (err_rd_ack |=> !err_rd_ack)
        else $error("ack too long");
    // an untaken character is neither dropped nor overwritten
    chk_valid_hold: assert property (rx_valid && !rx_ready && rx_enable_bit |=> rx_valid)
        else $error("rx_valid dropped");
    chk_data_hold: assert property ((rx_valid && !rx_ready && rx_enable_bit) [*2] |-> $stable(rx_data))
        else $error("rx_data overwritten");
    // line idles high; the start bit stays low at least two cycles
    chk_tx_idle: assert property (!tx_shift_busy_flag |-> serial_tx_line)
        else $error("tx line low while idle");
    chk_start_low: assert property ($rose(tx_shift_busy_flag) |-> !serial_tx_line ##1 !serial_tx_line)
        else $error("start bit too short");
    chk_done_pulse: assert property (tx_done_pulse |=> !tx_done_pulse)
        else $error("tx done too long");
    cover property ($rose(tx_buffer_full_flag));
    cover property (err_rd_ack && rx_error_status_reg[0]);
    cover property (rx_error_pulse);
endmodule
bind asu_top asu_top_chk i_asu_top_chk (
    .ref_clk, .rst_n, .rx_enable_bit, .rx_ready, .rx_valid, .rx_data, .err_rd_req, .err_rd_ack,
    .rx_error_status_reg, .tx_shift_busy_flag, .tx_buffer_full_flag, .tx_done_pulse, .rx_error_pulse,
    .serial_tx_line
);

/* File: verif/asu_top_test.sv */
`timescale 1ns/1ps
module asu_top_test;
    localparam BIT = 4;
    // design inputs
    reg ref_clk, rst_n, unit_power_bit, tx_enable_bit, rx_enable_bit, char_length_select;
    reg stop_length_select, rx_error_irq_select, tx_wr_valid, rx_ready, err_rd_req;
    reg [1:0] pm;
    reg [7:0] tx_byte;
    // design outputs, plus serial_rx_line driven by the remote node
    wire tx_wr_ready, rx_valid, err_rd_ack, tx_buffer_full_flag, tx_shift_busy_flag;
    wire tx_done_pulse, rx_error_pulse, rx_done_pulse, serial_rx_line, serial_tx_line;
    wire [7:0] rx_data;
    wire [2:0] rx_error_status_reg;
    // rows: parity mode, 8 bits, two stops, byte, expected parity bit
    reg [12:0] rows [0:5] = '{13'h054a, 13'h1479, 13'h1f02, 13'h08bc, 13'h1aff, 13'h1601};
    reg [1:0] m;
    reg c8, s2, p;
    reg [7:0] d;
    reg [15:0] f;
    reg [11:0] g;
    integer r, i, cyc = 0, err_total = 0, checked = 0;
    reg [11:0] n_rxd = 12'h000, n_rxe = 12'h000, n_txd = 12'h000;

    // divider 3 gives 4 cycles a bit, matching the remote node
    asu_top i_asu_top (
        .ref_clk, .rst_n, .unit_power_bit, .tx_enable_bit, .rx_enable_bit,
        .parity_mode_hi(pm[1]), .parity_mode_lo(pm[0]), .char_length_select, .stop_length_select,
        .rx_error_irq_select, .count_clock_div(16'h0003), .tx_wr_valid, .transmit_buffer(tx_byte),
        .tx_wr_ready, .rx_valid, .rx_data, .rx_ready, .err_rd_req, .err_rd_ack, .rx_error_status_reg,
        .tx_buffer_full_flag, .tx_shift_busy_flag, .tx_done_pulse, .rx_error_pulse, .rx_done_pulse,
        .serial_rx_line, .serial_tx_line
    );
    asu_remote_node #(.BIT(BIT)) i_asu_remote_node (.ref_clk, .rx_line(serial_rx_line), .tx_line(serial_tx_line));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // frame bits after the start bit, count in the top nibble
    function [15:0] frm(input [7:0] dd, input hp, cc, ss, pp, sb);
        reg [11:0] v;
        reg [3:0] k;
        begin
            v = {4'h0, dd};
            k = cc ? 4'h8 : 4'h7;
            if (!cc) v[7] = 1'b0;
            if (hp) begin
                v[k] = pp;
                k = k + 4'h1;
            end
            v[k] = sb;
            v[k + 1] = 1'b1;
            frm = {k + 4'h1 + {3'h0, ss}, v};
        end
    endfunction

    task cmp(input string n, input [11:0] e, input [11:0] v);
        checked = checked + 1;
        if (v !== e) begin
            err_total = err_total + 1;
            $display("mismatch %0s expected %h seen %h", n, e, v);
        end
    endtask

    task end_sim;
        if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // settings change only with both sides disabled
    task cfg(input [1:0] mm, input cc, ss);
        while (tx_shift_busy_flag !== 1'b0) @(posedge ref_clk);
        @(posedge ref_clk) tx_enable_bit <= 1'b0;
        rx_enable_bit <= 1'b0;
        @(posedge ref_clk) pm <= mm;
        char_length_select <= cc;
        stop_length_select <= ss;
        rx_error_irq_select <= ~rx_error_irq_select;
        @(posedge ref_clk) tx_enable_bit <= 1'b1;
        rx_enable_bit <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask

    task push(input [7:0] dd);
        @(posedge ref_clk) tx_wr_valid <= 1'b1;
        tx_byte <= dd;
        @(posedge ref_clk) tx_wr_valid <= 1'b0;
    endtask

    task drop;
        @(posedge ref_clk) rx_ready <= 1'b1;
        @(posedge ref_clk) rx_ready <= 1'b0;
    endtask

    task take(input [7:0] e);
        integer t;
        t = 0;
        while (rx_valid !== 1'b1 && t < 200) begin
            @(posedge ref_clk) #1;
            t = t + 1;
        end
        cmp("rx_data", e, rx_data);
        drop;
    endtask

    // request held until the edge that samples the acknowledge, one wait cycle between
    task rd(input [2:0] e);
        @(posedge ref_clk) err_rd_req <= 1'b1;
        repeat (3) @(posedge ref_clk);
        cmp("err_rd_ack", 12'h001, err_rd_ack);
        cmp("rx_error_status_reg", e, rx_error_status_reg);
        err_rd_req <= 1'b0;
    endtask

    // cut a hang short
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            end_sim;
        end
    end

    // tally the one-cycle strobes so they are checked as well
    always @(posedge ref_clk) begin
        if (rst_n) begin
            n_rxd <= n_rxd + {11'h000, rx_done_pulse};
            n_rxe <= n_rxe + {11'h000, rx_error_pulse};
            n_txd <= n_txd + {11'h000, tx_done_pulse};
        end
    end

    initial begin
        {rst_n, unit_power_bit, tx_enable_bit, rx_enable_bit, char_length_select, stop_length_select} = 6'h00;
        {rx_error_irq_select, tx_wr_valid, rx_ready, err_rd_req, pm, tx_byte} = 14'h0000;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        unit_power_bit <= 1'b1;
        for (r = 0; r < 6; r++) begin
            {m, c8, s2, d, p} = rows[r];
            cfg(m, c8, s2);
            f = frm(d, m != 0, c8, s2, p, 1'b1);
            push(d);
            i_asu_remote_node.recv(f[15:12], g);
            cmp("tx_frame", f[11:0] & ~(12'hfff << f[15:12]), g);
            i_asu_remote_node.send(frm(d, m != 0, c8, 1'b0, p, 1'b1));
            take(d & {c8, 7'h7f});
            rd(3'h0);
        end
        // nine writes back to back fill the buffer behind the shifter
        cfg(2'h0, 1'b1, 1'b0);
        fork
            begin
                @(posedge ref_clk) tx_wr_valid <= 1'b1;
                tx_byte <= 8'h10;
                for (r = 1; r < 9; r++) @(posedge ref_clk) tx_byte <= tx_byte + 8'h01;
                @(posedge ref_clk) tx_wr_valid <= 1'b0;
                repeat (2) @(posedge ref_clk);
                #1;
                cmp("tx_buffer_full_flag", 12'h001, tx_buffer_full_flag);
                cmp("tx_wr_ready", 12'h000, tx_wr_ready);
                cmp("tx_shift_busy_flag", 12'h001, tx_shift_busy_flag);
            end
            for (i = 0; i < 9; i++) begin
                i_asu_remote_node.recv(4'h9, g);
                d = 8'h10 + i[7:0];
                cmp("tx_burst", {4'h1, d}, g);
            end
        join
        // two stops set, frames one stop apart, first left untaken
        cfg(2'h0, 1'b1, 1'b1);
        i_asu_remote_node.send(frm(8'h3c, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1));
        i_asu_remote_node.send(frm(8'hc3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1));
        cmp("rx_data", 8'h3c, rx_data);
        rd(3'h1);
        take(8'h3c);
        // wrong parity in each parity mode
        for (r = 1; r < 4; r++) begin
            cfg(r[1:0], 1'b1, 1'b0);
            i_asu_remote_node.send(frm(8'h01, 1'b1, 1'b1, 1'b0, r != 3, 1'b1));
            rd(r == 1 ? 3'h0 : 3'h4);
            drop;
        end
        // low stop bit
        cfg(2'h0, 1'b1, 1'b0);
        i_asu_remote_node.send(frm(8'h55, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
        rd(3'h2);
        drop;
        // twelve frames received, four with an error, fifteen sent
        cmp("rx_done_count", 12'h00c, n_rxd);
        cmp("rx_error_count", 12'h004, n_rxe);
        cmp("tx_done_count", 12'h00f, n_txd);
        // reset in mid-run returns rx_valid, the tx flags, the error status and the tx line to idle
        @(posedge ref_clk) rst_n <= 1'b0;
        @(posedge ref_clk) rst_n <= 1'b1;
        #1;
        cmp("reset_state", 12'h001, {rx_valid, tx_shift_busy_flag, tx_buffer_full_flag, rx_error_status_reg,
            serial_tx_line});
        end_sim;
    end
endmodule
